//--- design/priority_interrupt_init_rotate.sv
// Purpose: eight-input priority interrupt controller, init sequence and rotation
// Assumes: all pins synchronous to mclk; strobes wider than one clock
// Notes:   status reads and polling are not part of this block
`timescale 1ns/1ps
// Function
// - write with port_select low and bit 4 set starts initialization
// - init clears edge detectors; request needs a fresh rising edge
// - init clears every mask bit
// - init restores fixed order: level 0 highest, level 7 lowest
// - init clears special masking and status read select
// - interval_select picks 4 or 8 byte vector spacing
// - single_flag set means no cascade_slave_map word follows
// - 4-byte low vector: address 7..5, level in 4..2, zeros below
// - 8-byte low vector: address 7..6, level in 5..3, zeros below
// - device inserts low bits; vector_high_byte supplies high byte
// - acknowledges give opcode, then low byte, then high byte
// - master: cascaded inputs get opcode only plus id on cascade lines
// - slave drives bytes two and three only when cascade id matches
// - each request masked by its own bit of mask_write_word
// - masked in-service level still inhibits lower ones unless special masking is set
// - acknowledge picks highest pending, sets its in-service bit
// - in-service blocks lower priorities, higher ones still interrupt
// - rotate with end flag clears highest in-service, makes it lowest
// - rotate with specific flag makes level_code bottom priority
// - specific rotate with end flag also clears in-service at level_code
// - non-specific end clears highest set in-service bit
module priority_interrupt_init_rotate (
   input  wire  logic       mclk,
   input  wire  logic       rst_n,
   input  wire  logic       cs_n,
   input  wire  logic       wr_n,
   input  wire  logic       port_select,
   input  wire  logic [7:0] data_in,
   output       logic [7:0] data_out_r,
   output       logic       data_oe_r,
   input  wire  logic       acknowledge_strobe_n,
   input  wire  logic [7:0] request_lines,
   output       logic       interrupt_r,
   input  wire  logic       master_sel,
   input  wire  logic [2:0] cascade_id_lines_in,
   output       logic [2:0] cascade_id_lines_out_r,
   output       logic       cascade_id_lines_oe_r
);
   pic_pkg::init_state_t state_r;
   pic_pkg::init_state_t state_nxt;
   logic [2:0] addr_hi_r;       // vector address bits 7..5
   logic       interval4_r;
   logic       single_r;
   logic [7:0] vector_high_byte_r;
   logic [7:0] cascade_slave_map_r;
   logic [7:0] mask_bits_r;
   logic [7:0] pending_request_bits_r;
   logic [7:0] in_service_bits_r;
   logic [7:0] edge_prev_r;
   logic [2:0] bottom_r;
   logic       special_masking_r;
   logic       read_select_r;
   logic       wr_prev_r;
   logic       ack_prev_r;
   logic [1:0] ack_cnt_r;
   logic [2:0] ack_level_r;
   logic       ack_casc_r;

   resolve_if rif ();
   priority_pick u_pick (.rif(rif));

   // write strobe decode
   wire       wr_take  = wr_prev_r & ~wr_n & ~cs_n;
   wire       init_wr  = wr_take & ~port_select & data_in[pic_pkg::INIT_FLAG_BIT];
   wire       ready    = (state_r == pic_pkg::ST_READY);
   wire       ctl_wr   = wr_take & ~port_select & ~data_in[pic_pkg::INIT_FLAG_BIT] & ready;
   wire       service_end_rotate_word_wr  = ctl_wr & ~data_in[pic_pkg::MODE_READ_SELECT_WORD_FLAG_BIT];
   wire       mode_read_select_word_wr  = ctl_wr & data_in[pic_pkg::MODE_READ_SELECT_WORD_FLAG_BIT];
   wire       hi_wr    = wr_take & port_select;
   wire       mask_wr  = hi_wr & ready;
   wire       rot_f    = data_in[pic_pkg::ROTATE_BIT];
   wire       spec_f   = data_in[pic_pkg::SPECIFIC_BIT];
   wire       end_f    = data_in[pic_pkg::SERVICE_END_BIT];
   wire [2:0] level_code = data_in[2:0];

   // acknowledge decode
   wire       ack_fall  = ack_prev_r & ~acknowledge_strobe_n;
   wire       first_ack = ack_fall & (ack_cnt_r == pic_pkg::PHASE_OPCODE);
   wire [2:0] pick_lvl  = rif.req_any ? rif.req_level : pic_pkg::LOWEST_LEVEL;
   wire       casc_hit  = master_sel & ~single_r & cascade_slave_map_r[pick_lvl];
   wire       id_match  = cascade_id_lines_in == cascade_slave_map_r[pic_pkg::SLAVE_ID_MSB:0];

   // resolver inputs; special masking lets masked in-service levels stop inhibiting
   assign rif.req_bits = pending_request_bits_r & ~mask_bits_r;
   assign rif.srv_bits = in_service_bits_r;
   assign rif.inh_bits = in_service_bits_r & ~(special_masking_r ? mask_bits_r : pic_pkg::ALL_CLEAR);
   assign rif.bottom   = bottom_r;

   // end-of-service clear; non-specific forms take the highest set bit
   wire [7:0] hi_srv  = rif.srv_any ? pic_pkg::level_bit(rif.srv_level) : pic_pkg::ALL_CLEAR;
   wire [7:0] eoi_clr = ~(service_end_rotate_word_wr & end_f) ? pic_pkg::ALL_CLEAR :
                        spec_f ? pic_pkg::level_bit(level_code) : hi_srv;
   wire       rot_auto = service_end_rotate_word_wr & rot_f & ~spec_f & end_f & rif.srv_any;
   wire       rot_spec = service_end_rotate_word_wr & rot_f & spec_f;
   wire [7:0] ack_set  = first_ack ? pic_pkg::level_bit(pick_lvl) : pic_pkg::ALL_CLEAR;
   wire [7:0] ack_clr  = first_ack & rif.req_any ? ack_set : pic_pkg::ALL_CLEAR;
   wire [7:0] req_edge = request_lines & ~edge_prev_r;

   // vector bytes
   wire [7:0] low4  = {addr_hi_r, ack_level_r, 2'h0};
   wire [7:0] low8  = {addr_hi_r[2:1], ack_level_r, 3'h0};
   wire [7:0] low_byte = interval4_r ? low4 : low8;
   wire [7:0] byte_sel = (ack_cnt_r == pic_pkg::PHASE_OPCODE) ? pic_pkg::CALL_OPCODE :
                         (ack_cnt_r == pic_pkg::PHASE_LOW)    ? low_byte : vector_high_byte_r;
   wire       drive_sel = (ack_cnt_r == pic_pkg::PHASE_OPCODE) ? master_sel :
                          master_sel ? ~ack_casc_r : id_match;

   // init word sequencer
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         pic_pkg::ST_READY: state_nxt = state_r;
         pic_pkg::ST_VEC:   if (hi_wr) state_nxt = single_r ? pic_pkg::ST_READY : pic_pkg::ST_CASC;
         pic_pkg::ST_CASC:  if (hi_wr) state_nxt = pic_pkg::ST_READY;
         default:           state_nxt = pic_pkg::ST_READY;
      endcase
      if (init_wr) state_nxt = pic_pkg::ST_VEC;
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= pic_pkg::ST_READY;
      end else begin
         state_r <= state_nxt;
      end
   end

   // init word one fields and the two later init words
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         addr_hi_r           <= 3'h0;
         interval4_r         <= 1'b0;
         single_r            <= 1'b1;
         vector_high_byte_r  <= pic_pkg::ALL_CLEAR;
         cascade_slave_map_r <= pic_pkg::ALL_CLEAR;
      end else begin
         if (init_wr) begin
            addr_hi_r   <= data_in[7:pic_pkg::ADDR_HI_LSB];
            interval4_r <= data_in[pic_pkg::INTERVAL4_BIT];
            single_r    <= data_in[pic_pkg::SINGLE_BIT];
         end
         if (hi_wr && state_r == pic_pkg::ST_VEC) vector_high_byte_r <= data_in;
         if (hi_wr && state_r == pic_pkg::ST_CASC) cascade_slave_map_r <= data_in;
      end
   end

   // mask, priority and mode flags; init overrides any command in the same write
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         mask_bits_r       <= pic_pkg::ALL_CLEAR;
         bottom_r          <= pic_pkg::LOWEST_LEVEL;
         special_masking_r <= 1'b0;
         read_select_r     <= 1'b0;
      end else if (init_wr) begin
         mask_bits_r       <= pic_pkg::ALL_CLEAR;
         bottom_r          <= pic_pkg::LOWEST_LEVEL;
         special_masking_r <= 1'b0;
         read_select_r     <= 1'b0;
      end else begin
         if (mask_wr) mask_bits_r <= data_in;
         if (rot_auto) bottom_r <= rif.srv_level;
         else if (rot_spec) bottom_r <= level_code;
         if (mode_read_select_word_wr && data_in[pic_pkg::ESMM_BIT])
            special_masking_r <= data_in[pic_pkg::SMM_BIT];
         if (mode_read_select_word_wr && data_in[pic_pkg::ERIS_BIT])
            read_select_r <= data_in[0];
      end
   end

   // request and service bits; a new edge wins over the acknowledge clear
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         edge_prev_r            <= pic_pkg::ALL_SET;
         pending_request_bits_r <= pic_pkg::ALL_CLEAR;
         in_service_bits_r      <= pic_pkg::ALL_CLEAR;
      end else begin
         edge_prev_r            <= init_wr ? pic_pkg::ALL_SET : request_lines;
         pending_request_bits_r <= init_wr ? pic_pkg::ALL_CLEAR
                                   : (pending_request_bits_r & ~ack_clr) | req_edge;
         in_service_bits_r      <= (in_service_bits_r & ~eoi_clr) | ack_set;
      end
   end

   // strobe history and acknowledge counting; init restarts the count
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wr_prev_r   <= 1'b1;
         ack_prev_r  <= 1'b1;
         ack_cnt_r   <= pic_pkg::PHASE_OPCODE;
         ack_level_r <= 3'h0;
         ack_casc_r  <= 1'b0;
      end else begin
         wr_prev_r  <= wr_n | cs_n;
         ack_prev_r <= acknowledge_strobe_n;
         if (init_wr) ack_cnt_r <= pic_pkg::PHASE_OPCODE;
         else if (ack_fall)
            ack_cnt_r <= (ack_cnt_r == pic_pkg::PHASE_HIGH) ? pic_pkg::PHASE_OPCODE
                         : 2'(ack_cnt_r + 2'h1);
         if (first_ack) begin
            ack_level_r <= pick_lvl;
            ack_casc_r  <= casc_hit;
         end
      end
   end

   // bus and cascade drivers; bus released once the strobe goes high, cascade lines only after the third pulse
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         data_out_r             <= pic_pkg::ALL_CLEAR;
         data_oe_r              <= 1'b0;
         cascade_id_lines_out_r <= 3'h0;
         cascade_id_lines_oe_r  <= 1'b0;
         interrupt_r            <= 1'b0;
      end else begin
         interrupt_r <= rif.int_want;
         if (ack_fall) begin
            data_out_r <= byte_sel;
            data_oe_r  <= drive_sel;
         end else if (acknowledge_strobe_n) begin
            data_oe_r  <= 1'b0;
         end
         if (first_ack) begin
            cascade_id_lines_out_r <= pick_lvl;
            cascade_id_lines_oe_r  <= casc_hit;
         end else if (ack_cnt_r == pic_pkg::PHASE_OPCODE && acknowledge_strobe_n) begin
            cascade_id_lines_oe_r  <= 1'b0;
         end
      end
   end

   // checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   sequence s_init;
      init_wr;
   endsequence
   sequence s_low_fetch;
      ack_fall && ack_cnt_r == pic_pkg::PHASE_LOW;
   endsequence

   chk_init_start: assert property (s_init |=> state_r == pic_pkg::ST_VEC)
      else $error("init write did not start the sequence");
   chk_edge_rearm: assert property (s_init |=> edge_prev_r == pic_pkg::ALL_SET
                                    && pending_request_bits_r == pic_pkg::ALL_CLEAR)
      else $error("edge detectors not cleared by init");
   chk_init_unmask: assert property (s_init |=> mask_bits_r == pic_pkg::ALL_CLEAR)
      else $error("mask not cleared by init");
   chk_init_order: assert property (s_init |=> bottom_r == pic_pkg::LOWEST_LEVEL)
      else $error("fixed order not restored by init");
   chk_init_modes: assert property (s_init |=> !special_masking_r && !read_select_r)
      else $error("mode flags not cleared by init");
   chk_single_skip: assert property (state_r == pic_pkg::ST_VEC && hi_wr && single_r
                                     && !init_wr |=> ready)
      else $error("cascade word expected with single set");
   chk_low_four: assert property (s_low_fetch and interval4_r
                                  |=> data_out_r == {addr_hi_r, ack_level_r, 2'h0})
      else $error("4-byte low vector wrong");
   chk_low_eight: assert property (s_low_fetch and !interval4_r
                                   |=> data_out_r == {addr_hi_r[2:1], ack_level_r, 3'h0})
      else $error("8-byte low vector wrong");
   chk_opcode_first: assert property (first_ack && master_sel
                                      |=> data_oe_r && data_out_r == pic_pkg::CALL_OPCODE)
      else $error("opcode not driven on first acknowledge");
   chk_slave_quiet: assert property (s_low_fetch and !master_sel && !id_match
                                     |=> !data_oe_r)
      else $error("slave drove vector without id match");
   chk_mask_load: assert property (mask_wr && !init_wr |=> mask_bits_r == $past(data_in))
      else $error("mask word not loaded");
   chk_auto_rotate: assert property (rot_auto |=> bottom_r == $past(rif.srv_level)
                     && !in_service_bits_r[$past(rif.srv_level)])
      else $error("auto rotate wrong");
   chk_spec_rotate: assert property (rot_spec && !init_wr
                                     |=> bottom_r == $past(level_code))
      else $error("specific rotate wrong");
endmodule : priority_interrupt_init_rotate

//--- design/pic_pkg.sv
// Purpose: shared constants and types of the eight-input interrupt controller
// Assumes: byte-wide host bus, all fields in the low byte
// Notes:   bit positions name command word fields
package pic_pkg;
   // command word field positions
   localparam int INIT_FLAG_BIT   = 4;   // set with port_select low: first init word
   localparam int MODE_READ_SELECT_WORD_FLAG_BIT   = 3;   // set: mode_read_select_word
   localparam int INTERVAL4_BIT   = 2;   // interval_select: 1 = 4 byte spacing
   localparam int SINGLE_BIT      = 1;   // single_flag: no cascade_slave_map word
   localparam int ADDR_HI_LSB     = 5;   // vector address bits 7..5 in init_word_one
   localparam int ROTATE_BIT      = 7;
   localparam int SPECIFIC_BIT    = 6;
   localparam int SERVICE_END_BIT = 5;
   localparam int ESMM_BIT        = 6;
   localparam int SMM_BIT         = 5;
   localparam int ERIS_BIT        = 1;
   localparam int SLAVE_ID_MSB    = 2;

   // values
   localparam logic [7:0] CALL_OPCODE  = 8'hCD;
   localparam logic [7:0] ALL_CLEAR    = 8'h00;
   localparam logic [7:0] ALL_SET      = 8'hFF;
   localparam logic [2:0] LOWEST_LEVEL = 3'h7;  // bottom priority after init
   localparam logic [1:0] PHASE_OPCODE = 2'h0;
   localparam logic [1:0] PHASE_LOW    = 2'h1;
   localparam logic [1:0] PHASE_HIGH   = 2'h2;

   typedef enum logic [2:0] {
      ST_READY = 3'b001,
      ST_VEC   = 3'b010,
      ST_CASC  = 3'b100
   } init_state_t;

   // one-hot bit of a level
   function automatic logic [7:0] level_bit(input logic [2:0] lvl);
      level_bit = 8'h01 << lvl;
   endfunction : level_bit
endpackage : pic_pkg

//--- design/resolve_if.sv
// Purpose: carries request and service vectors to the priority resolver
// Assumes: purely combinational exchange
// Notes:   levels are absolute request line numbers
`timescale 1ns/1ps
interface resolve_if;
   logic [7:0] req_bits;   // eligible pending requests
   logic [7:0] srv_bits;   // in-service bits
   logic [7:0] inh_bits;   // in-service bits that inhibit
   logic [2:0] bottom;     // bottom priority level
   logic       req_any;
   logic [2:0] req_level;
   logic       srv_any;
   logic [2:0] srv_level;
   logic       int_want;

   modport pick (input req_bits, srv_bits, inh_bits, bottom,
                 output req_any, req_level, srv_any, srv_level, int_want);
   modport user (output req_bits, srv_bits, inh_bits, bottom,
                 input req_any, req_level, srv_any, srv_level, int_want);
endinterface : resolve_if

//--- design/priority_pick.sv
// Purpose: rotating priority resolver
// Assumes: rank 0 is the level just above bottom
// Notes:   vectors are rotated so a plain first-set search gives priority
`timescale 1ns/1ps
module priority_pick (
   resolve_if.pick rif
);
   logic [7:0] rot_req;
   logic [7:0] rot_srv;
   logic [7:0] rot_inh;
   logic [3:0] req_hit;
   logic [3:0] srv_hit;
   logic [3:0] inh_hit;

   // lowest set index with a found flag on top
   function automatic logic [3:0] first_set(input logic [7:0] v);
      logic [3:0] r;
      r = 4'h0;
      for (int i = 7; i >= 0; i--) begin
         if (v[i]) r = {1'b1, 3'(i)};
      end
      return r;
   endfunction : first_set

   // rank g holds the level bottom+1+g, wrapping 7 to 0
   genvar g;
   for (g = 0; g < 8; g++) begin : g_rot
      wire [2:0] lvl = 3'(rif.bottom + 3'(g) + 3'h1);
      assign rot_req[g] = rif.req_bits[lvl];
      assign rot_srv[g] = rif.srv_bits[lvl];
      assign rot_inh[g] = rif.inh_bits[lvl];
   end

   assign req_hit = first_set(rot_req);
   assign srv_hit = first_set(rot_srv);
   assign inh_hit = first_set(rot_inh);

   assign rif.req_any   = req_hit[3];
   assign rif.req_level = 3'(rif.bottom + req_hit[2:0] + 3'h1);
   assign rif.srv_any   = srv_hit[3];
   assign rif.srv_level = 3'(rif.bottom + srv_hit[2:0] + 3'h1);
   // a request only beats strictly higher ranks of in-service levels
   assign rif.int_want  = req_hit[3] && (!inh_hit[3] || req_hit[2:0] < inh_hit[2:0]);
endmodule : priority_pick

//--- bench/host_model.sv
// Purpose: host processor model: command writes and acknowledge pulses
// Assumes: wr_n returns high for at least one cycle between writes
// Notes:   released data lines show the inverse of the last byte, never a stale copy
`timescale 1ns/1ps
module host_model (
   input  wire  logic       mclk,
   output       logic       cs_n,
   output       logic       wr_n,
   output       logic       port_select,
   output       logic [7:0] data_in,
   output       logic       acknowledge_strobe_n,
   input  wire  logic [7:0] data_out_r,
   input  wire  logic       data_oe_r
);
   // idle bus from time zero
   initial begin
      cs_n                 = 1'b1;
      wr_n                 = 1'b1;
      port_select          = 1'b0;
      data_in              = 8'h00;
      acknowledge_strobe_n = 1'b1;
   end

   // one write: held up to the take edge, then released with a spare high cycle
   task automatic wr(input logic ps, input logic [7:0] d);
      @(posedge mclk);
      cs_n        <= 1'b0;
      wr_n        <= 1'b0;
      port_select <= ps;
      data_in     <= d;
      @(posedge mclk);
      cs_n    <= 1'b1;
      wr_n    <= 1'b1;
      data_in <= ~d;  // bus no longer driven with the old byte
      @(posedge mclk);
   endtask : wr

   // three pulses per interrupt; byte and drive flag sampled while strobe is low
   task automatic ack3(output logic [7:0] b [3], output logic [2:0] oe);
      for (int i = 0; i < 3; i++) begin
         @(posedge mclk);
         acknowledge_strobe_n <= 1'b0;
         repeat (3) @(posedge mclk);
         #1;
         b[i]  = data_out_r;
         oe[i] = data_oe_r;
         @(posedge mclk);
         acknowledge_strobe_n <= 1'b1;
         repeat (3) @(posedge mclk);
      end
   endtask : ack3
endmodule : host_model

//--- bench/priority_interrupt_init_rotate_tb.sv
// Purpose: self-checking bench for the interrupt controller
// Assumes: one clock at 100 MHz, host model drives the command port
// Notes:   scenarios run in sequence; each re-initialises the block
`timescale 1ns/1ps
module priority_interrupt_init_rotate_tb;
   logic       mclk;
   logic       rst_n;
   logic       cs_n;
   logic       wr_n;
   logic       port_select;
   logic [7:0] data_in;
   logic [7:0] data_out_r;
   logic       data_oe_r;
   logic       acknowledge_strobe_n;
   logic [7:0] request_lines;
   logic       interrupt_r;
   logic       master_sel;
   logic [2:0] cascade_id_lines_in;
   logic [2:0] cascade_id_lines_out_r;
   logic       cascade_id_lines_oe_r;
   logic [7:0] ab [3];
   logic [2:0] aoe;
   logic [2:0] casc_seen;
   logic       casc_hit;
   int         fails;
   int         compares;

   // 10 ns clock
   initial mclk = 1'b0;
   always #5 mclk = ~mclk;

   priority_interrupt_init_rotate priority_interrupt_init_rotate_i (
      .mclk(mclk), .rst_n(rst_n), .cs_n(cs_n), .wr_n(wr_n), .port_select(port_select),
      .data_in(data_in), .data_out_r(data_out_r), .data_oe_r(data_oe_r),
      .acknowledge_strobe_n(acknowledge_strobe_n), .request_lines(request_lines),
      .interrupt_r(interrupt_r), .master_sel(master_sel),
      .cascade_id_lines_in(cascade_id_lines_in),
      .cascade_id_lines_out_r(cascade_id_lines_out_r),
      .cascade_id_lines_oe_r(cascade_id_lines_oe_r));

   host_model host_model_i (
      .mclk(mclk), .cs_n(cs_n), .wr_n(wr_n), .port_select(port_select), .data_in(data_in),
      .acknowledge_strobe_n(acknowledge_strobe_n), .data_out_r(data_out_r),
      .data_oe_r(data_oe_r));

   // remember what the master put on the cascade lines
   always @(posedge mclk) begin
      if (cascade_id_lines_oe_r === 1'b1) begin
         casc_seen <= cascade_id_lines_out_r;
         casc_hit  <= 1'b1;
      end
   end

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : final_report

   // cascade word only follows when single_flag is clear
   task automatic do_init(input logic [7:0] w1, input logic [7:0] w2, input logic [7:0] w3);
      host_model_i.wr(1'b0, w1);
      host_model_i.wr(1'b1, w2);
      if (w1[pic_pkg::SINGLE_BIT] == 1'b0) host_model_i.wr(1'b1, w3);
   endtask : do_init

   task automatic set_req(input logic [7:0] v);
      @(posedge mclk);
      request_lines <= v;
   endtask : set_req

   // interrupt settles two cycles after its cause; a few spare cycles given
   task automatic int_is(input logic exp);
      repeat (6) @(posedge mclk);
      #1;
      check("interrupt", {7'h00, interrupt_r}, {7'h00, exp});
   endtask : int_is

   task automatic ack_exp(input logic [7:0] lo, input logic [7:0] hi, input logic [2:0] eoe);
      host_model_i.ack3(ab, aoe);
      check("drive flags", {5'h00, aoe}, {5'h00, eoe});
      if (eoe[0]) check("call byte", ab[0], pic_pkg::CALL_OPCODE);
      if (eoe[1]) check("low vector", ab[1], lo);
      if (eoe[2]) check("high vector", ab[2], hi);
   endtask : ack_exp

   task automatic scen_nested();
      do_init(8'hB6, 8'h12, 8'h00);
      set_req(8'h20);
      int_is(1'b1);
      ack_exp(8'hB4, 8'h12, 3'h7);
      host_model_i.wr(1'b1, 8'h20);
      set_req(8'h60);
      int_is(1'b0);
      set_req(8'h64);
      int_is(1'b1);
      ack_exp(8'hA8, 8'h12, 3'h7);
      host_model_i.wr(1'b0, 8'h20);
      int_is(1'b0);
      host_model_i.wr(1'b0, 8'h20);
      int_is(1'b1);
      ack_exp(8'hB8, 8'h12, 3'h7);
      host_model_i.wr(1'b0, 8'h20);
   endtask : scen_nested

   task automatic scen_spacing();
      set_req(8'h00);
      do_init(8'hD2, 8'h34, 8'h00);
      host_model_i.wr(1'b1, 8'h08);
      set_req(8'h08);
      int_is(1'b0);
      do_init(8'hD2, 8'h34, 8'h00);
      int_is(1'b0);
      set_req(8'h00);
      set_req(8'h08);
      int_is(1'b1);
      ack_exp(8'hD8, 8'h34, 3'h7);
      // masked level 3 in service holds off level 4 until special masking is on
      host_model_i.wr(1'b1, 8'h08);
      set_req(8'h18);
      int_is(1'b0);
      host_model_i.wr(1'b0, 8'h68);
      int_is(1'b1);
      // init must drop special masking, so the masked in-service level inhibits again
      do_init(8'hD2, 8'h34, 8'h00);
      host_model_i.wr(1'b1, 8'h08);
      set_req(8'h08);
      set_req(8'h18);
      int_is(1'b0);
      host_model_i.wr(1'b0, 8'h20);
   endtask : scen_spacing

   task automatic scen_rotate();
      set_req(8'h00);
      do_init(8'h16, 8'h56, 8'h00);
      host_model_i.wr(1'b0, 8'hC4);
      set_req(8'h48);
      int_is(1'b1);
      ack_exp(8'h18, 8'h56, 3'h7);
      host_model_i.wr(1'b0, 8'hA0);
      set_req(8'h28);
      ack_exp(8'h0C, 8'h56, 3'h7);
      set_req(8'h00);
      host_model_i.wr(1'b0, 8'hE3);
      set_req(8'h08);
      int_is(1'b1);
      ack_exp(8'h14, 8'h56, 3'h7);
      host_model_i.wr(1'b0, 8'h20);
      // level 3 only interrupts if the specific end cleared its in-service bit
      int_is(1'b1);
      ack_exp(8'h0C, 8'h56, 3'h7);
      host_model_i.wr(1'b0, 8'h20);
      set_req(8'h00);
      do_init(8'h16, 8'h56, 8'h00);
      set_req(8'h81);
      ack_exp(8'h00, 8'h56, 3'h7);
      host_model_i.wr(1'b0, 8'h20);
   endtask : scen_rotate

   task automatic scen_cascade();
      set_req(8'h00);
      do_init(8'h14, 8'h40, 8'h04);
      set_req(8'h04);
      int_is(1'b1);
      ack_exp(8'h00, 8'h00, 3'h1);
      check("cascade id", {5'h00, casc_seen}, 8'h02);
      check("cascade drive", {7'h00, casc_hit}, 8'h01);
      host_model_i.wr(1'b0, 8'h20);
      set_req(8'h00);
      master_sel          <= 1'b0;
      cascade_id_lines_in <= 3'h3;
      do_init(8'h14, 8'h40, 8'h03);
      set_req(8'h02);
      ack_exp(8'h04, 8'h40, 3'h6);
      cascade_id_lines_in <= 3'h5;
      set_req(8'h03);
      ack_exp(8'h00, 8'h00, 3'h0);
   endtask : scen_cascade

   // main sequence
   initial begin
      rst_n               = 1'b0;
      master_sel          = 1'b1;
      request_lines       = 8'h00;
      cascade_id_lines_in = 3'h0;
      fails               = 0;
      compares            = 0;
      repeat (10) @(posedge mclk);
      rst_n <= 1'b1;
      scen_nested();
      scen_spacing();
      scen_rotate();
      scen_cascade();
      final_report();
   end

   // hang guard: the whole run is far shorter than this
   initial begin
      repeat (20000) @(posedge mclk);
      fails++;
      final_report();
   end
endmodule : priority_interrupt_init_rotate_tb
